//--- verilog/srff_formatter.sv
// Reply field formatter: APB registers, reply sequencer and output buffer.
//
// Notes on behaviour
// - Serial number is twelve characters: Y M DD - NN - B S PP.
// - Month letter A..M skipping I, January is A, December is M.
// - Batch letter A..Z, oven slot digit 1..5, slot position 1..15.
// - Pressure range: low, space, to, space, high, space, unit, mode.
// - Pressure mode letter is A absolute, D differential or G gauge.
// - Temperature range: low, space, high, space, then letter C.
// - Error field is a 16-bit flag word sent as four hex characters.
// - Error bit 0 flags an uncompensated part, never set once calibrated.
// - Error bits 1..7 flag internal compensation computation faults.
// - Error bit 8 flags pressure beyond range, output clamped to limit.
// - Error bits 9..15 are reserved and always sent as zero.
// - An addressed reply is complete: echo letters, equals, fields, CR.
// - Addressed command with another serial number gets no reply at all.
// - Every command and response ends with a carriage return.
// - Addressed reply starts with U, own serial number and a space.
// - Any error other than bit 8 forces the pressure field to 8000.
//
// Design decisions made here: the APB register port and the address map.
`include "srff_params.svh"
`timescale 1ns/1ns
`default_nettype none

module srff_formatter
	import srff_pkg::*;
(
	input  wire logic        ref_clk,  // 10 MHz clock
	input  wire logic        resetn,   // async reset, active low
	input  wire logic        psel,     // APB select
	input  wire logic        penable,  // APB enable
	input  wire logic        pwrite,   // APB direction
	input  wire logic [7:0]  paddr,    // APB byte address
	input  wire logic [31:0] pwdata,   // APB write data
	output logic      [31:0] prdata,   // APB read data
	output logic             pready,   // APB ready
	output logic             pslverr,  // APB error, unmapped address
	input  wire logic [15:0] press_in, // compensated pressure count
	input  wire logic [8:0]  err_in,   // compensation error flags
	output logic      [7:0]  tx_data,  // reply byte to the UART
	output logic             tx_valid, // reply byte valid
	input  wire logic        tx_ready, // UART takes the byte
	output logic             busy      // reply in progress
);

	logic [31:0]    prdata_ff, p_lo_ff, p_hi_ff, p_unit_ff;
	logic [31:0]    t_lo_ff, t_hi_ff;
	logic           pready_ff, pslverr_ff, addressed_ff;
	logic           silent_ff, bad_ff;
	logic [7:0]     letter_ff;
	srff_sn_type    own_sn_ff, tgt_sn_ff;
	logic [1:0]     p_mode_ff;
	logic [15:0]    err_snap_ff, press_snap_ff;
	srff_state_type st_ff;
	logic [4:0]     pos_ff;
	srff_kind_type  kind_ff;
	srff_byte_type  head_ff, spare_ff;

	logic [31:0]   rd_word;
	logic          rd_hit, wr_acc, go, kind_ok, cur_last;
	logic          in_ready, push, step, pop;
	srff_kind_type kind_sel;
	logic [7:0]    cur_byte;
	logic [15:0]   err_word, press_word;
	function automatic logic [7:0] hex_ch(input logic [3:0] n);
		hex_ch = (n < 4'hA) ? (`SRFF_CH_ZERO + 8'(n))
			: (`SRFF_CH_A + 8'(n - 4'hA));
	endfunction
	function automatic logic [7:0] dig(input logic [7:0] v);
		dig = `SRFF_CH_ZERO + v;
	endfunction
	function automatic logic [7:0] str_ch(input logic [31:0] w,
		input logic [1:0] i);
		str_ch = w[8'd31 - {3'h0, i, 3'h0} -: 8];
	endfunction
	function automatic logic [7:0] sn_ch(input srff_sn_type s,
		input logic [4:0] k);
		logic [7:0] mo;
		mo = 8'(s.month);
		case (k)
			5'd0: sn_ch = dig(8'(s.year));
			5'd1: sn_ch = (mo <= 8'h08) ? (`SRFF_CH_MONTH_LO + mo)
				: (`SRFF_CH_MONTH_HI + mo);
			5'd2: sn_ch = dig(8'(s.day / 5'd10));
			5'd3: sn_ch = dig(8'(s.day % 5'd10));
			5'd5: sn_ch = dig(8'(s.lot / 7'd10));
			5'd6: sn_ch = dig(8'(s.lot % 7'd10));
			5'd8: sn_ch = `SRFF_CH_A + 8'(s.batch);
			5'd9: sn_ch = dig(8'(s.slot));
			5'd10: sn_ch = dig(8'(s.pos / 4'd10));
			5'd11: sn_ch = dig(8'(s.pos % 4'd10));
			default: sn_ch = `SRFF_CH_DASH;
		endcase
	endfunction
	// APB decode; every access takes one wait state.
	assign wr_acc = psel & penable & pready_ff & pwrite;
	assign go = wr_acc & (paddr == `SRFF_A_CTRL)
		& pwdata[`SRFF_CTRL_GO_BIT] & (st_ff == S_IDLE);
	assign err_word = {7'h00, err_in};
	assign press_word = |(err_in & `SRFF_ERR_CALC)
		? `SRFF_PRESS_ERR : press_in;
	always_comb begin
		rd_hit = 1'b1;
		rd_word = 32'h0000_0000;
		case (paddr)
			`SRFF_A_CTRL: rd_word = {22'h0, addressed_ff, 1'b0, letter_ff};
			`SRFF_A_STAT: rd_word = {29'h0, bad_ff, silent_ff,
				st_ff != S_IDLE};
			`SRFF_A_OWN_SN: rd_word = own_sn_ff;
			`SRFF_A_TGT_SN: rd_word = tgt_sn_ff;
			`SRFF_A_P_LO: rd_word = p_lo_ff;
			`SRFF_A_P_HI: rd_word = p_hi_ff;
			`SRFF_A_P_UNIT: rd_word = p_unit_ff;
			`SRFF_A_P_MODE: rd_word = {30'h0, p_mode_ff};
			`SRFF_A_T_LO: rd_word = t_lo_ff;
			`SRFF_A_T_HI: rd_word = t_hi_ff;
			`SRFF_A_ERR: rd_word = {16'h0, err_snap_ff};
			`SRFF_A_PRESS: rd_word = {16'h0, press_snap_ff};
			default: rd_hit = 1'b0;
		endcase
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= `SRFF_RST_WORD;
		end else begin
			pready_ff <= psel & penable & ~pready_ff;
			pslverr_ff <= psel & penable & ~pready_ff & ~rd_hit;
			prdata_ff <= (psel & penable & ~pready_ff & ~pwrite & rd_hit)
				? rd_word : `SRFF_RST_WORD;
		end
	end
	// Writable setup registers; writes to read-only words are dropped.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			letter_ff <= `SRFF_RST_LETTER;
			addressed_ff <= 1'b0;
			own_sn_ff <= `SRFF_RST_WORD;
			tgt_sn_ff <= `SRFF_RST_WORD;
			p_lo_ff <= `SRFF_RST_WORD;
			p_hi_ff <= `SRFF_RST_WORD;
			p_unit_ff <= `SRFF_RST_WORD;
			p_mode_ff <= `SRFF_RST_MODE;
			t_lo_ff <= `SRFF_RST_WORD;
			t_hi_ff <= `SRFF_RST_WORD;
		end else if (wr_acc) begin
			case (paddr)
				`SRFF_A_CTRL: begin
					letter_ff <= pwdata[7:0];
					addressed_ff <= pwdata[`SRFF_CTRL_ADDR_BIT];
				end
				`SRFF_A_OWN_SN: own_sn_ff <= pwdata;
				`SRFF_A_TGT_SN: tgt_sn_ff <= pwdata;
				`SRFF_A_P_LO: p_lo_ff <= pwdata;
				`SRFF_A_P_HI: p_hi_ff <= pwdata;
				`SRFF_A_P_UNIT: p_unit_ff <= pwdata;
				`SRFF_A_P_MODE: p_mode_ff <= pwdata[1:0];
				`SRFF_A_T_LO: t_lo_ff <= pwdata;
				`SRFF_A_T_HI: t_hi_ff <= pwdata;
				default: ;
			endcase
		end
	end
	// The command letter picks which field set the reply carries.
	always_comb begin
		kind_ok = 1'b1;
		kind_sel = K_PV;
		case (pwdata[7:0])
			`SRFF_CH_R: kind_sel = K_PR;
			`SRFF_CH_S: kind_sel = K_SN;
			`SRFF_CH_T: kind_sel = K_TR;
			`SRFF_CH_L, `SRFF_CH_H, `SRFF_CH_C: kind_sel = K_PV;
			default: kind_ok = 1'b0;
		endcase
	end
	// Snapshots keep the error and pressure fields stable for one reply.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			err_snap_ff <= 16'h0000;
			press_snap_ff <= 16'h0000;
		end else if (go) begin
			// Bit 0 and bits 1..7 captured as flagged.
			// Bit 8 passes through with the clamped value.
			err_snap_ff <= err_word;
			press_snap_ff <= press_word;
		end
	end
	always_comb begin
		cur_byte = `SRFF_CH_CR;
		cur_last = 1'b1;
		case (st_ff)
			S_IDLE: cur_byte = 8'h00;
			S_HDR: begin
				cur_last = (pos_ff == `SRFF_LAST_HDR);
				if (pos_ff == 5'd0) begin
					cur_byte = `SRFF_CH_U;
				end else if (cur_last) begin
					cur_byte = `SRFF_CH_SP;
				end else begin
					cur_byte = sn_ch(own_sn_ff, pos_ff - 5'd1);
				end
			end
			S_ECHO: begin
				cur_last = (pos_ff == `SRFF_LAST_ECHO);
				case (pos_ff)
					5'd0: cur_byte = `SRFF_CH_R;
					5'd1: cur_byte = letter_ff;
					default: cur_byte = `SRFF_CH_EQ;
				endcase
			end
			S_FIELD: begin
				unique case (kind_ff)
					K_SN: begin
						cur_last = (pos_ff == `SRFF_LAST_SN);
						cur_byte = sn_ch(own_sn_ff, pos_ff);
					end
					K_PR: begin
						// Range text; zero bytes are skipped.
						cur_last = (pos_ff == `SRFF_LAST_PR);
						cur_byte = `SRFF_CH_SP;
						if (pos_ff <= 5'd3) begin
							cur_byte = str_ch(p_lo_ff, pos_ff[1:0]);
						end else if (pos_ff == 5'd5) begin
							cur_byte = `SRFF_CH_TLOW;
						end else if (pos_ff == 5'd6) begin
							cur_byte = `SRFF_CH_O;
						end else if (pos_ff >= 5'd8 && pos_ff <= 5'd11) begin
							cur_byte = str_ch(p_hi_ff, 2'(pos_ff - 5'd8));
						end else if (pos_ff >= 5'd13 && pos_ff <= 5'd16) begin
							cur_byte = str_ch(p_unit_ff, 2'(pos_ff - 5'd13));
						end else if (cur_last) begin
							cur_byte = (p_mode_ff == 2'h0) ? `SRFF_CH_A
								: (p_mode_ff == 2'h1) ? `SRFF_CH_D
								: `SRFF_CH_G;
						end
					end
					K_TR: begin
						cur_last = (pos_ff == `SRFF_LAST_TR);
						cur_byte = `SRFF_CH_SP;
						if (pos_ff <= 5'd3) begin
							cur_byte = str_ch(t_lo_ff, pos_ff[1:0]);
						end else if (pos_ff >= 5'd5 && pos_ff <= 5'd8) begin
							cur_byte = str_ch(t_hi_ff, 2'(pos_ff - 5'd5));
						end else if (cur_last) begin
							cur_byte = `SRFF_CH_C;
						end
					end
					K_PV: begin
						// Four hex digits each; MS nibble first.
						cur_last = (pos_ff == `SRFF_LAST_PV);
						cur_byte = `SRFF_CH_SP;
						if (pos_ff <= 5'd3) begin
							cur_byte = hex_ch(press_snap_ff[
								5'd15 - {1'b0, pos_ff[1:0], 2'b00} -: 4]);
						end else if (pos_ff >= 5'd5) begin
							cur_byte = hex_ch(err_snap_ff[
								5'd15 - {1'b0, 2'(pos_ff - 5'd5), 2'b00} -: 4]);
						end
					end
				endcase
			end
			S_TERM: cur_byte = `SRFF_CH_CR;
			default: cur_byte = 8'h00;
		endcase
	end
	assign in_ready = ~spare_ff.valid;
	assign push = (st_ff != S_IDLE) & in_ready & (cur_byte != 8'h00);
	assign step = (st_ff != S_IDLE) & (in_ready | (cur_byte == 8'h00));
	// Sequencer; a stalled UART holds it on the current byte.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= S_IDLE;
			pos_ff <= 5'd0;
			kind_ff <= K_PV;
		end else if (go) begin
			pos_ff <= 5'd0;
			kind_ff <= kind_sel;
			// Mismatched serial: stay idle, send nothing.
			if (!kind_ok || (pwdata[`SRFF_CTRL_ADDR_BIT]
				&& tgt_sn_ff != own_sn_ff)) begin
				st_ff <= S_IDLE;
			end else if (pwdata[`SRFF_CTRL_ADDR_BIT]) begin
				st_ff <= S_HDR;
			end else begin
				st_ff <= S_ECHO;
			end
		end else if (step) begin
			pos_ff <= cur_last ? 5'd0 : pos_ff + 5'd1;
			if (cur_last) begin
				unique case (st_ff)
					S_HDR: st_ff <= S_ECHO;
					S_ECHO: st_ff <= S_FIELD;
					S_FIELD: st_ff <= S_TERM;
					S_TERM: st_ff <= S_IDLE;
					S_IDLE: st_ff <= S_IDLE;
				endcase
			end
		end
	end
	// Sticky outcome flags; each new start reloads them from its own outcome.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			silent_ff <= 1'b0;
			bad_ff <= 1'b0;
		end else if (go) begin
			silent_ff <= kind_ok & pwdata[`SRFF_CTRL_ADDR_BIT]
				& (tgt_sn_ff != own_sn_ff);
			bad_ff <= ~kind_ok;
		end
	end
	// Two-entry buffer: head drives the port, spare absorbs one stall.
	assign pop = head_ff.valid & tx_ready;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			head_ff <= '0;
			spare_ff <= '0;
		end else if (pop) begin
			if (spare_ff.valid) begin
				head_ff <= spare_ff;
				spare_ff.valid <= 1'b0;
			end else begin
				head_ff <= {push, cur_byte};
			end
		end else if (push) begin
			if (!head_ff.valid) begin
				head_ff <= {1'b1, cur_byte};
			end else begin
				spare_ff <= {1'b1, cur_byte};
			end
		end
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'b0;
		end else begin
			busy <= (st_ff != S_IDLE) | go;
		end
	end
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign tx_data = head_ff.data;
	assign tx_valid = head_ff.valid;

endmodule

`default_nettype wire

//--- verilog/srff_params.svh
// Offsets, field positions, character codes and lengths of the reply formatter.
`ifndef SRFF_PARAMS_SVH
`define SRFF_PARAMS_SVH

`define SRFF_A_CTRL      8'h00
`define SRFF_A_STAT      8'h04
`define SRFF_A_OWN_SN    8'h08
`define SRFF_A_TGT_SN    8'h0C
`define SRFF_A_P_LO      8'h10
`define SRFF_A_P_HI      8'h14
`define SRFF_A_P_UNIT    8'h18
`define SRFF_A_P_MODE    8'h1C
`define SRFF_A_T_LO      8'h20
`define SRFF_A_T_HI      8'h24
`define SRFF_A_ERR       8'h28
`define SRFF_A_PRESS     8'h2C

`define SRFF_CTRL_ADDR_BIT  8
`define SRFF_CTRL_GO_BIT    9
`define SRFF_STAT_BUSY_BIT  0
`define SRFF_STAT_SIL_BIT   1
`define SRFF_STAT_BAD_BIT   2

`define SRFF_RST_WORD    32'h0000_0000
`define SRFF_RST_LETTER  8'h53
`define SRFF_RST_MODE    2'h0

`define SRFF_CH_CR       8'h0D
`define SRFF_CH_SP       8'h20
`define SRFF_CH_DASH     8'h2D
`define SRFF_CH_EQ       8'h3D
`define SRFF_CH_ZERO     8'h30
`define SRFF_CH_A        8'h41
`define SRFF_CH_C        8'h43
`define SRFF_CH_D        8'h44
`define SRFF_CH_G        8'h47
`define SRFF_CH_H        8'h48
`define SRFF_CH_L        8'h4C
`define SRFF_CH_O        8'h6F
`define SRFF_CH_R        8'h52
`define SRFF_CH_S        8'h53
`define SRFF_CH_T        8'h54
`define SRFF_CH_TLOW     8'h74
`define SRFF_CH_U        8'h55
`define SRFF_CH_MONTH_LO 8'h40
`define SRFF_CH_MONTH_HI 8'h41

`define SRFF_LAST_HDR    5'd13
`define SRFF_LAST_ECHO   5'd2
`define SRFF_LAST_SN     5'd11
`define SRFF_LAST_PR     5'd17
`define SRFF_LAST_TR     5'd10
`define SRFF_LAST_PV     5'd8

`define SRFF_PRESS_ERR   16'h8000
`define SRFF_ERR_CALC    9'h0FF

`endif

//--- verilog/srff_pkg.sv
// Types shared by the reply field formatter.
package srff_pkg;

	typedef enum logic [2:0] {
		S_IDLE,
		S_HDR,
		S_ECHO,
		S_FIELD,
		S_TERM
	} srff_state_type;

	typedef enum logic [1:0] {
		K_PR,
		K_SN,
		K_TR,
		K_PV
	} srff_kind_type;

	typedef struct packed {
		logic [3:0] pos;
		logic [2:0] slot;
		logic [4:0] batch;
		logic [6:0] lot;
		logic [4:0] day;
		logic [3:0] month;
		logic [3:0] year;
	} srff_sn_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} srff_byte_type;

endpackage

//--- test/srff_checker.sv
// Port-level assertions for the reply field formatter.
`timescale 1ns/1ns
`default_nettype none

module srff_checker (
	input wire logic        ref_clk,  // clock
	input wire logic        resetn,   // reset, active low
	input wire logic        psel,     // APB select
	input wire logic        penable,  // APB enable
	input wire logic        pwrite,   // APB direction
	input wire logic [7:0]  paddr,    // APB address
	input wire logic [31:0] pwdata,   // APB write data
	input wire logic [31:0] prdata,   // APB read data
	input wire logic        pready,   // APB ready
	input wire logic        pslverr,  // APB error
	input wire logic [7:0]  tx_data,  // reply byte
	input wire logic        tx_valid, // reply byte valid
	input wire logic        tx_ready, // host takes byte
	input wire logic        busy      // reply running
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_setup;
		psel && !penable ##1 psel && penable;
	endsequence

	sequence s_go;
		psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[9]
			&& !pwdata[8] && !busy && pwdata[7:0] inside {8'h52, 8'h53, 8'h54};
	endsequence

	chk_wait_state:
		assert property (s_setup |-> !pready ##1 pready)
		else $error("pready not on second access edge");
	chk_ready_pulse:
		assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_idle_data:
		assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("read data or error outside answer");
	chk_unmapped_err:
		assert property (pready && (paddr > 8'h2C || paddr[1:0] != 2'h0)
			|-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_mapped_ok:
		assert property (pready && paddr <= 8'h2C && paddr[1:0] == 2'h0
			|-> !pslverr)
		else $error("mapped access refused");
	chk_err_reserved:
		assert property (pready && !pwrite && paddr == 8'h28
			|-> prdata[31:9] == 23'h0)
		else $error("reserved error bits not zero");
	chk_tx_hold:
		assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte lost during stall");
	chk_go_reply:
		assert property (s_go |=> busy ##1 tx_valid)
		else $error("reply did not start after go");
endmodule

`default_nettype wire

//--- test/srff_host_sink.sv
// Host-side model that takes reply bytes from the formatter.
`timescale 1ns/1ns
`default_nettype none

module srff_host_sink (
	input wire logic       ref_clk,  // clock
	input wire logic       resetn,   // reset, active low
	input wire logic [7:0] tx_data,  // reply byte
	input wire logic       tx_valid, // reply byte valid
	input wire logic       slow,     // stall every other cycle
	output logic           tx_ready  // byte taken
);
	logic [7:0] rx_q[$];
	int         replies;

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_ready <= 1'b0;
			replies <= 0;
		end else begin
			if (tx_valid && tx_ready) begin
				rx_q.push_back(tx_data);
				if (tx_data == 8'h0D)
					replies <= replies + 1;
			end
			tx_ready <= slow ? !tx_ready : 1'b1;
		end
	end
endmodule

`default_nettype wire

//--- test/tb_top.sv
// Testbench for the reply field formatter.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic        ref_clk, resetn, psel, penable, pwrite, slow;
	logic [7:0]  paddr, tx_data;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, tx_valid, tx_ready, busy;
	logic [15:0] press_in;
	logic [8:0]  err_in;
	int          fails, checked, k;
	logic [31:0] r;
	logic        e;
	logic [15:0] pv[4] = '{16'h3F7C, 16'h1D58, 16'h1234, 16'hABCD};
	logic [8:0]  ev[4] = '{9'h100, 9'h000, 9'h001, 9'h0A0};
	logic [7:0]  lt[4] = '{8'h4C, 8'h48, 8'h43, 8'h4C};
	string       xs[4] = '{"RL=3F7C 0100\015", "RH=1D58 0000\015",
		"RC=8000 0001\015", "RL=8000 00A0\015"};
	string       ms[3] = '{"A", "D", "G"};
	logic [15:0] qv[4] = '{16'h3F7C, 16'h1D58, 16'h8000, 16'h8000};

	srff_formatter i_dut (.ref_clk, .resetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .press_in, .err_in,
		.tx_data, .tx_valid, .tx_ready, .busy);
	srff_host_sink i_host (.ref_clk, .resetn, .tx_data, .tx_valid, .slow,
		.tx_ready);

	always #50 ref_clk = ~ref_clk;

	task stop_test;
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk_word(input string name, input logic [31:0] x, input logic [31:0] y);
		checked++;
		if (x !== y) begin
			$display("Error %s expected %h seen %h", name, x, y);
			fails++;
		end
	endtask

	task chk_text(input string x);
		int i;
		checked++;
		if (i_host.rx_q.size() != x.len()) begin
			$display("Error reply length expected %0d seen %0d", x.len(),
				i_host.rx_q.size());
			fails++;
		end else
			for (i = 0; i < x.len(); i++)
				if (i_host.rx_q[i] !== x[i]) begin
					$display("Error reply byte %0d expected %h seen %h", i, x[i],
						i_host.rx_q[i]);
					fails++;
					break;
				end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge ref_clk);
			if (pready === 1'b1)
				break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 100) begin
			$display("Error apb ready expected 1 seen 0");
			fails++;
			stop_test;
		end
	endtask

	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk_word($sformatf("reg %h", a), x, r);
	endtask

	task reply(input logic [9:0] cmd, input string x);
		int n;
		i_host.rx_q.delete();
		apb(1'b1, 8'h00, {22'h0, cmd});
		// a missing reply ends in the timeout
		for (n = 0; n < 2000; n++) begin
			@(negedge ref_clk);
			if (busy === 1'b0 && i_host.rx_q.size() >= x.len())
				break;
		end
		if (n == 2000) begin
			$display("Error reply end expected %0d seen %0d", x.len(),
				i_host.rx_q.size());
			fails++;
			stop_test;
		end
		repeat (4) @(posedge ref_clk);
		chk_text(x);
	endtask

	initial begin
		ref_clk = 1'b0;
		resetn = 1'b0;
		{psel, penable, pwrite, slow} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		press_in = 16'h0000;
		err_in = 9'h000;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(8'h00, 32'h0000_0053);
		rd(8'h04, 32'h0000_0000);
		rd(8'h08, 32'h0000_0000);
		apb(1'b0, 8'h30, 32'h0);
		chk_word("slverr", 32'h1, {31'h0, e});
		apb(1'b1, 8'h04, 32'hFFFF_FFFF);
		rd(8'h04, 32'h0000_0000);
		apb(1'b1, 8'h08, 32'h3200_7743);
		reply(10'h253, "RS=3D23-03-A103\015");
		apb(1'b1, 8'h08, 32'hFB91_8199);
		slow <= 1'b1;
		reply(10'h253, "RS=9J01-12-Z515\015");
		slow <= 1'b0;
		apb(1'b1, 8'h10, 32'h0000_3230);
		apb(1'b1, 8'h14, 32'h0000_3332);
		apb(1'b1, 8'h18, 32'h6D6D_4867);
		for (k = 0; k < 3; k++) begin
			apb(1'b1, 8'h1C, k);
			reply(10'h252, {"RR=20 to 32 mmHg", ms[k], "\015"});
		end
		apb(1'b1, 8'h20, 32'h002D_3230);
		apb(1'b1, 8'h24, 32'h0000_3835);
		reply(10'h254, "RT=-20 85 C\015");
		for (k = 0; k < 4; k++) begin
			press_in <= pv[k];
			err_in <= ev[k];
			reply({2'b10, lt[k]}, xs[k]);
			rd(8'h28, {23'h0, ev[k]});
			rd(8'h2C, {16'h0, qv[k]});
		end
		apb(1'b1, 8'h0C, 32'hFB91_8199);
		reply(10'h354, "U9J01-12-Z515 RT=-20 85 C\015");
		apb(1'b1, 8'h0C, 32'hFB91_8198);
		reply(10'h354, "");
		rd(8'h04, 32'h0000_0002);
		reply(10'h258, "");
		rd(8'h04, 32'h0000_0004);
		chk_word("replies", 32'd11, i_host.replies);
		stop_test;
	end
endmodule

bind srff_formatter srff_checker i_chk (.ref_clk, .resetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_data,
	.tx_valid, .tx_ready, .busy);

`default_nettype wire
